//--- core/arcm_defs.svh
// Overview of operation
// - The gain calibration middle byte is a read/write register at 0xac, cleared by reset.
// - The gain calibration low byte is a read/write register at 0xab, cleared by reset.
// - The main-filter result reads as high at 0xc5, middle at 0xc4, low at 0xc3.
// - On the 24-bit variant the low byte holds result bits 7-0; all result bytes reset to 0.
// - The fast-filter result is separate; bits 23-16 at 0xfe and 7-0 at 0xfc (15-8 and zero on the 16-bit variant), reset to 0.
// - Positive and negative converter inputs each have their own independent selector.
// - Codes 0-7 pick external inputs, code 15 picks the temperature sensor, others ground.
// - The input select register at 0xc6 holds positive code in 7-4, negative in 3-0.
// - The temperature sensor turns on whenever either selector chooses it.
// - Either input may be grounded, and the sensor works single-ended or differential.
`ifndef ARCM_DEFS_SVH
`define ARCM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses.
// ----------------------------------------------------------------------------
`define ARCM_ADDR_GAIN_CAL_LOW    8'hab
`define ARCM_ADDR_GAIN_CAL_MID    8'hac
`define ARCM_ADDR_MAIN_LOW        8'hc3
`define ARCM_ADDR_MAIN_MID        8'hc4
`define ARCM_ADDR_MAIN_HIGH       8'hc5
`define ARCM_ADDR_INPUT_SELECT    8'hc6
`define ARCM_ADDR_FAST_LOW        8'hfc
`define ARCM_ADDR_FAST_HIGH       8'hfe

// ----------------------------------------------------------------------------
// Reset values and field positions.
// ----------------------------------------------------------------------------
`define ARCM_RESET_BYTE           8'h00
`define ARCM_POS_CODE_MSB         7
`define ARCM_POS_CODE_LSB         4
`define ARCM_NEG_CODE_MSB         3
`define ARCM_NEG_CODE_LSB         0
`define ARCM_CODE_EXT_MAX         4'h7
`define ARCM_CODE_TEMP            4'hf

`endif

//--- core/arcm_pkg.sv
`include "arcm_defs.svh"

package arcm_pkg;

    // ------------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ARCM_SRC_EXTERNAL = 2'h1,
        ARCM_SRC_TEMP     = 2'h2
    } arcm_src_kind_t;

    // One selector's decoded source; ground when neither external nor temp.
    typedef struct packed {
        logic       external;
        logic [2:0] channel;
        logic       temp;
        logic       ground;
    } arcm_route_t;

    // A full 24-bit conversion result from a filter.
    typedef struct packed {
        logic        load;
        logic [23:0] value;
    } arcm_result_t;

    // Processor special-function-register access.
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } arcm_sfr_req_t;

endpackage : arcm_pkg

//--- core/arcm_regs.sv
`include "arcm_defs.svh"

module arcm_regs #(
    parameter bit IS_24BIT = 1'b1
) (
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    input  wire arcm_pkg::arcm_sfr_req_t sfr_in,
    output logic [7:0]                  sfr_rdata_out,
    output logic                        sfr_hit_out,
    input  wire arcm_pkg::arcm_result_t main_in,
    input  wire arcm_pkg::arcm_result_t fast_in,
    output logic [15:0]                 gain_cal_value_out,
    output arcm_pkg::arcm_route_t       positive_route_out,
    output arcm_pkg::arcm_route_t       negative_route_out,
    output logic                        temp_sensor_on_out
);
    import arcm_pkg::*;

    logic [7:0] gain_cal_low;
    logic [7:0] gain_cal_mid;
    logic [7:0] main_result_low;
    logic [7:0] main_result_mid;
    logic [7:0] main_result_high;
    logic [7:0] input_select;
    logic [7:0] fast_result_low;
    logic [7:0] fast_result_high;
    logic [3:0] positive_input_code;
    logic [3:0] negative_input_code;
    logic [7:0] next_input_select;
    logic [7:0] write_strobe;
    logic [1:0][3:0] selector_code;

    // ------------------------------------------------------------------------
    // Slots of the mapped registers in the write strobe vector.
    // ------------------------------------------------------------------------
    localparam int SLOT_GAIN_LOW     = 0;
    localparam int SLOT_GAIN_MID     = 1;
    localparam int SLOT_MAIN_LOW     = 2;
    localparam int SLOT_MAIN_MID     = 3;
    localparam int SLOT_MAIN_HIGH    = 4;
    localparam int SLOT_INPUT_SELECT = 5;
    localparam int SLOT_FAST_LOW     = 6;
    localparam int SLOT_FAST_HIGH    = 7;

    // Reset code zero routes both inputs to external input 0, sensor off.
    localparam arcm_route_t ROUTE_AT_RESET = '{external: 1'b1, channel: 3'h0,
                                               temp: 1'b0, ground: 1'b0};

    // ------------------------------------------------------------------------
    // Selector decode, shared by both inputs.
    // ------------------------------------------------------------------------
    function automatic arcm_route_t decode_code(input logic [3:0] code);
        arcm_route_t r;
        r = '0;
        if (code <= `ARCM_CODE_EXT_MAX) begin
            r.external = 1'b1;
            r.channel  = code[2:0];
        end else if (code == `ARCM_CODE_TEMP) begin
            r.temp = 1'b1;
        end else begin
            r.ground = 1'b1; // Grounding one side gives single-ended use.
        end
        return r;
    endfunction : decode_code

    // ------------------------------------------------------------------------
    // Address decode, shared by the write strobes and the hit flag.
    // ------------------------------------------------------------------------
    // One bit per mapped register; an unmapped address gives all zeros, so a
    // stray write touches nothing and the hit flag stays low.
    function automatic logic [7:0] map_address(input logic [7:0] addr);
        logic [7:0] slot;
        slot = 8'h00;
        unique case (addr)
            `ARCM_ADDR_GAIN_CAL_LOW: slot[SLOT_GAIN_LOW]     = 1'b1;
            `ARCM_ADDR_GAIN_CAL_MID: slot[SLOT_GAIN_MID]     = 1'b1;
            `ARCM_ADDR_MAIN_LOW:     slot[SLOT_MAIN_LOW]     = 1'b1;
            `ARCM_ADDR_MAIN_MID:     slot[SLOT_MAIN_MID]     = 1'b1;
            `ARCM_ADDR_MAIN_HIGH:    slot[SLOT_MAIN_HIGH]    = 1'b1;
            `ARCM_ADDR_INPUT_SELECT: slot[SLOT_INPUT_SELECT] = 1'b1;
            `ARCM_ADDR_FAST_LOW:     slot[SLOT_FAST_LOW]     = 1'b1;
            `ARCM_ADDR_FAST_HIGH:    slot[SLOT_FAST_HIGH]    = 1'b1;
            default:                 slot                    = 8'h00;
        endcase
        return slot;
    endfunction : map_address

    // Write strobes are qualified here once, so every register block below
    // sees the same decode.
    assign write_strobe = sfr_in.wr ? map_address(sfr_in.addr) : 8'h00;

    // ------------------------------------------------------------------------
    // Calibration registers, written by software.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            gain_cal_low <= `ARCM_RESET_BYTE;
            gain_cal_mid <= `ARCM_RESET_BYTE;
        end else begin
            if (write_strobe[SLOT_GAIN_LOW]) begin
                gain_cal_low <= sfr_in.wdata;
            end
            if (write_strobe[SLOT_GAIN_MID]) begin
                gain_cal_mid <= sfr_in.wdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Input select register and its next value.
    // ------------------------------------------------------------------------
    // Nothing here holds off a write while a conversion runs: changing the
    // selection mid-conversion mixes two inputs, so software must wait for idle.
    always_comb begin
        next_input_select = input_select;
        if (write_strobe[SLOT_INPUT_SELECT]) begin
            next_input_select = sfr_in.wdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            input_select <= `ARCM_RESET_BYTE;
        end else begin
            input_select <= next_input_select;
        end
    end

    // ------------------------------------------------------------------------
    // Main-filter result bytes; a filter load wins over a software write.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            main_result_low  <= `ARCM_RESET_BYTE;
            main_result_mid  <= `ARCM_RESET_BYTE;
            main_result_high <= `ARCM_RESET_BYTE;
        end else if (main_in.load) begin
            if (IS_24BIT) begin
                main_result_high <= main_in.value[23:16];
                main_result_mid  <= main_in.value[15:8];
                main_result_low  <= main_in.value[7:0];
            end else begin
                // The 16-bit result sits one byte up; the low byte is unused.
                main_result_high <= main_in.value[15:8];
                main_result_mid  <= main_in.value[7:0];
                main_result_low  <= `ARCM_RESET_BYTE;
            end
        end else begin
            if (write_strobe[SLOT_MAIN_LOW]) main_result_low <= sfr_in.wdata;
            if (write_strobe[SLOT_MAIN_MID]) main_result_mid <= sfr_in.wdata;
            if (write_strobe[SLOT_MAIN_HIGH]) main_result_high <= sfr_in.wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Fast-filter result bytes, held apart from the main filter.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fast_result_low  <= `ARCM_RESET_BYTE;
            fast_result_high <= `ARCM_RESET_BYTE;
        end else if (fast_in.load) begin
            if (IS_24BIT) begin
                fast_result_high <= fast_in.value[23:16];
                fast_result_low  <= fast_in.value[7:0];
            end else begin
                fast_result_high <= fast_in.value[15:8];
                fast_result_low  <= `ARCM_RESET_BYTE;
            end
        end else begin
            if (write_strobe[SLOT_FAST_LOW]) fast_result_low <= sfr_in.wdata;
            if (write_strobe[SLOT_FAST_HIGH]) fast_result_high <= sfr_in.wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Read path; unmapped addresses read zero and leave the hit flag low.
    // ------------------------------------------------------------------------
    always_comb begin
        sfr_rdata_out = 8'h00;
        unique case (sfr_in.addr)
            `ARCM_ADDR_GAIN_CAL_LOW: sfr_rdata_out = gain_cal_low;
            `ARCM_ADDR_GAIN_CAL_MID: sfr_rdata_out = gain_cal_mid;
            `ARCM_ADDR_MAIN_LOW:     sfr_rdata_out = main_result_low;
            `ARCM_ADDR_MAIN_MID:     sfr_rdata_out = main_result_mid;
            `ARCM_ADDR_MAIN_HIGH:    sfr_rdata_out = main_result_high;
            `ARCM_ADDR_INPUT_SELECT: sfr_rdata_out = input_select;
            `ARCM_ADDR_FAST_LOW:     sfr_rdata_out = fast_result_low;
            `ARCM_ADDR_FAST_HIGH:    sfr_rdata_out = fast_result_high;
            default:                 sfr_rdata_out = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // Independent selectors and automatic sensor enable.
    // ------------------------------------------------------------------------
    // The codes come from the next value, so the registered routes change on
    // the same edge as the register itself.
    assign positive_input_code = next_input_select[`ARCM_POS_CODE_MSB:`ARCM_POS_CODE_LSB];
    assign negative_input_code = next_input_select[`ARCM_NEG_CODE_MSB:`ARCM_NEG_CODE_LSB];
    assign selector_code       = {positive_input_code, negative_input_code};

    // Slot 1 follows the positive code and slot 0 the negative one. Each slot
    // decodes only its own code, so neither input limits the other's choice.
    for (genvar s = 0; s < 2; s++) begin : g_selector
        arcm_route_t route;

        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                route <= ROUTE_AT_RESET;
            end else begin
                route <= decode_code(selector_code[s]);
            end
        end
    end

    assign positive_route_out = g_selector[1].route;
    assign negative_route_out = g_selector[0].route;

    // The sensor switches on with the selection itself, with no enable bit of
    // its own; either side may take it, for single-ended or differential use.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            temp_sensor_on_out <= 1'b0;
        end else begin
            temp_sensor_on_out <= (positive_input_code == `ARCM_CODE_TEMP)
                                | (negative_input_code == `ARCM_CODE_TEMP);
        end
    end

    // The gain bytes are flip-flops already, so the value goes out directly.
    assign gain_cal_value_out = {gain_cal_mid, gain_cal_low};

    // The hit flag uses the same decode as the write strobes.
    assign sfr_hit_out = |map_address(sfr_in.addr);

endmodule : arcm_regs

//--- dv/arcm_regs_monitor.sv
module arcm_regs_monitor
    import arcm_pkg::*;
#(
    parameter bit IS_24BIT = 1'b1
) (
    input wire logic                    clk_in,
    input wire logic                    rst_in,
    input wire arcm_pkg::arcm_sfr_req_t sfr_in,
    input wire logic [7:0]              sfr_rdata_out,
    input wire arcm_pkg::arcm_result_t  main_in,
    input wire arcm_pkg::arcm_result_t  fast_in,
    input wire logic [15:0]             gain_cal_value_out,
    input wire arcm_pkg::arcm_route_t   positive_route_out,
    input wire arcm_pkg::arcm_route_t   negative_route_out,
    input wire logic                    temp_sensor_on_out
);
    // ------------------------------------------------------------------
    // Expected source kind {external, temp, ground} for one selector code.
    // ------------------------------------------------------------------
    function automatic logic [2:0] kind(logic [3:0] c);
        return {!c[3], c == 4'hf, c[3] && c != 4'hf};
    endfunction : kind

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Each check ties an output to the write or load that caused it.
    a_gain_mid_write: assert property (sfr_in.wr && sfr_in.addr == 8'hac
        |=> gain_cal_value_out[15:8] == $past(sfr_in.wdata)) else $error("gain middle byte");
    a_gain_low_write: assert property (sfr_in.wr && sfr_in.addr == 8'hab
        |=> gain_cal_value_out[7:0] == $past(sfr_in.wdata)) else $error("gain low byte");
    a_main_high_load: assert property (main_in.load ##1 sfr_in.addr == 8'hc5
        |-> sfr_rdata_out == (IS_24BIT ? $past(main_in.value[23:16])
        : $past(main_in.value[15:8]))) else $error("main high byte");
    a_main_mid_load: assert property (main_in.load ##1 sfr_in.addr == 8'hc4
        |-> sfr_rdata_out == (IS_24BIT ? $past(main_in.value[15:8])
        : $past(main_in.value[7:0]))) else $error("main middle byte");
    a_main_low_load: assert property (main_in.load ##1 sfr_in.addr == 8'hc3
        |-> sfr_rdata_out == (IS_24BIT ? $past(main_in.value[7:0]) : 8'h00))
        else $error("main low byte");
    a_fast_high_load: assert property (fast_in.load ##1 sfr_in.addr == 8'hfe
        |-> sfr_rdata_out == (IS_24BIT ? $past(fast_in.value[23:16])
        : $past(fast_in.value[15:8]))) else $error("fast high byte");
    a_pos_kind_decode: assert property (sfr_in.wr && sfr_in.addr == 8'hc6
        |=> {positive_route_out.external, positive_route_out.temp, positive_route_out.ground}
        == kind($past(sfr_in.wdata[7:4]))) else $error("positive source kind");
    a_neg_kind_decode: assert property (sfr_in.wr && sfr_in.addr == 8'hc6
        |=> {negative_route_out.external, negative_route_out.temp, negative_route_out.ground}
        == kind($past(sfr_in.wdata[3:0]))) else $error("negative source kind");
    a_pos_channel_pick: assert property (sfr_in.wr && sfr_in.addr == 8'hc6 && !sfr_in.wdata[7]
        |=> positive_route_out.channel == $past(sfr_in.wdata[6:4])) else $error("channel");
    a_sensor_auto_on: assert property (sfr_in.wr && sfr_in.addr == 8'hc6
        |=> temp_sensor_on_out == ($past(sfr_in.wdata[7:4]) == 4'hf
        || $past(sfr_in.wdata[3:0]) == 4'hf)) else $error("sensor enable");

    c_main_load: cover property (main_in.load);
    c_fast_load: cover property (fast_in.load);
    c_sensor_on: cover property (temp_sensor_on_out);
endmodule : arcm_regs_monitor

bind arcm_regs arcm_regs_monitor #(.IS_24BIT(IS_24BIT)) mon_u (.clk_in, .rst_in, .sfr_in,
    .sfr_rdata_out,
    .main_in, .fast_in, .gain_cal_value_out, .positive_route_out,
    .negative_route_out, .temp_sensor_on_out);

//--- dv/arcm_regs_tb.sv
module arcm_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import arcm_pkg::*;
    logic          clk_in = 1'b0;
    logic          rst_in = 1'b1;
    arcm_sfr_req_t sfr = '0;
    arcm_result_t  main_r = '0;
    arcm_result_t  fast_r = '0;
    logic [7:0]    rdata;
    logic [7:0]    rdata16;
    logic          hit;
    logic          temp_on;
    logic [15:0]   gain;
    arcm_route_t   pos;
    arcm_route_t   neg;
    int            n_fail = 0;
    int            check_count = 0;

    arcm_regs dut_u (.clk_in, .rst_in, .sfr_in(sfr), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
        .main_in(main_r), .fast_in(fast_r), .gain_cal_value_out(gain),
        .positive_route_out(pos), .negative_route_out(neg), .temp_sensor_on_out(temp_on));
    // The 16-bit variant shares the stimulus; only its read data is judged.
    arcm_regs #(.IS_24BIT(1'b0)) dut16_u (.clk_in, .rst_in, .sfr_in(sfr),
        .sfr_rdata_out(rdata16), .sfr_hit_out(), .main_in(main_r), .fast_in(fast_r),
        .gain_cal_value_out(), .positive_route_out(), .negative_route_out(),
        .temp_sensor_on_out());

    // ------------------------------------------------------------------
    // Bus tasks; reads are combinational, so data is looked at 1 ns late.
    // ------------------------------------------------------------------
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_in);
        sfr <= '{a, 1'b1, 1'b0, d};
        @(posedge clk_in);
        sfr.wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk_in);
        sfr.addr <= a;
        #1 chk("read data", {8'h00, exp}, {8'h00, rdata});
    endtask : rd
    function automatic logic [5:0] exp_route(logic [3:0] c);
        return {!c[3], c == 4'hf, c[3] && c != 4'hf, c[3] ? 3'h0 : c[2:0]};
    endfunction : exp_route
    function automatic logic [5:0] seen(arcm_route_t r);
        return {r.external, r.temp, r.ground, r.channel & {3{r.external}}};
    endfunction : seen

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] a [8] = '{8'hab, 8'hac, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hfc, 8'hfe};
        foreach (a[i]) rd(a[i], 8'h00);
        chk("reset gain", 16'h0000, gain);
        chk("reset route", {10'h000, exp_route(4'h0)}, {10'h000, seen(pos)});
        chk("reset sensor", 16'h0000, {15'h0000, temp_on});
    endtask : t_reset
    // Unmapped write must leave the calibration value alone.
    task automatic t_gain();
        wr(8'hac, 8'h5a);
        wr(8'hab, 8'hc3);
        wr(8'had, 8'h77);
        rd(8'had, 8'h00);
        chk("hit", 16'h0000, {15'h0000, hit});
        rd(8'hac, 8'h5a);
        chk("hit", 16'h0001, {15'h0000, hit});
        rd(8'hab, 8'hc3);
        chk("gain", 16'h5ac3, gain);
    endtask : t_gain
    // A load collides with a write to the byte read; the load must win.
    task automatic t_results();
        logic [7:0] a [5] = '{8'hc5, 8'hc4, 8'hc3, 8'hfe, 8'hfc};
        logic [7:0] e [5] = '{8'h12, 8'h34, 8'h56, 8'hab, 8'hef};
        // The 16-bit variant sits one byte up and leaves the low bytes at zero.
        logic [7:0] f [5] = '{8'h34, 8'h56, 8'h00, 8'hcd, 8'h00};
        foreach (a[i]) begin
            @(posedge clk_in);
            main_r <= '{1'b1, 24'h123456};
            fast_r <= '{1'b1, 24'habcdef};
            sfr <= '{a[i], 1'b1, 1'b0, 8'h99};
            @(posedge clk_in);
            main_r.load <= 1'b0;
            fast_r.load <= 1'b0;
            sfr.wr <= 1'b0;
            #1 chk("result", {8'h00, e[i]}, {8'h00, rdata});
            chk("result16", {8'h00, f[i]}, {8'h00, rdata16});
        end
        // With no load pending, a software write to a result byte sticks.
        wr(8'hc4, 8'h99);
        rd(8'hc4, 8'h99);
    endtask : t_results
    // Every code on each side; the offset of 9 pairs positive sensor with negative ground, and negative sensor with positive input 6.
    task automatic t_mux();
        logic [3:0] p;
        logic [3:0] n;
        for (int c = 0; c < 16; c++) begin
            p = c[3:0];
            n = p + 4'h9;
            wr(8'hc6, {p, n}); // No load runs while the selection changes.
            #1 chk("positive", {10'h000, exp_route(p)}, {10'h000, seen(pos)});
            chk("negative", {10'h000, exp_route(n)}, {10'h000, seen(neg)});
            chk("sensor", {15'h0000, p == 4'hf || n == 4'hf}, {15'h0000, temp_on});
            rd(8'hc6, {p, n});
        end
    endtask : t_mux

    task automatic conclude();
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    // Reset for ten cycles, then the scenarios in turn.
    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_gain();
        t_results();
        t_mux();
        conclude();
    end
endmodule : arcm_regs_tb
